/* design/crf_first_pick.sv */
`timescale 1ns/1ns
module crf_first_pick #(
	parameter int N = 31,
	parameter int IW = 5
) (
	// candidates
	input wire logic [N-1:0] req,
	// lowest candidate
	output logic found,
	output logic [IW-1:0] idx
);
	// scan downward so the lowest index is written last and wins
	always_comb begin
		found = 1'b0;
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				found = 1'b1;
				idx = IW'(i);
			end
		end
	end

endmodule : crf_first_pick

/* design/crf_id_match.sv */
`timescale 1ns/1ns
module crf_id_match
	import crf_pkg::*;
(
	// received frame
	input wire logic [ID_W-1:0] rx_id,
	input wire logic rx_ide,
	// mailbox filter setting
	input wire logic [31:0] mb_id,
	input wire logic [31:0] mask,
	input wire logic mask_en,
	// result
	output logic hit
);
	logic [31:0] eff_mask;
	logic [ID_W-1:0] sel;
	logic fmt_ok;

	// a disabled mask compares everything, format included
	assign eff_mask = mask_en ? mask : RST_ZERO;
	assign fmt_ok = eff_mask[MSK_FMT_BIT] | (rx_ide == mb_id[MBID_IDE_BIT]);
	// standard frames only look at the upper 11 bits
	assign sel = (rx_ide ? EXT_SEL : STD_SEL) & ~eff_mask[ID_W-1:0];
	assign hit = fmt_ok & (((rx_id ^ mb_id[ID_W-1:0]) & sel) == '0);

endmodule : crf_id_match

/* design/crf_pkg.sv */
package crf_pkg;

	// mailbox count and identifier layout
	localparam int NUM_MB = 32;
	localparam int ID_W = 29;
	localparam int MB_W = 5;
	localparam int ADDR_W = 8;

	// register byte offsets
	localparam logic [7:0] OFS_RMP = 8'h00;
	localparam logic [7:0] OFS_RML = 8'h04;
	localparam logic [7:0] OFS_RFP = 8'h08;
	localparam logic [7:0] OFS_GIM = 8'h0C;
	localparam logic [7:0] OFS_GAM = 8'h10;
	localparam logic [7:0] OFS_LAM = 8'h14;
	localparam logic [7:0] OFS_MBDIR = 8'h18;
	localparam logic [7:0] OFS_MBAME = 8'h1C;
	localparam logic [7:0] OFS_MBIDX = 8'h20;
	localparam logic [7:0] OFS_MBID = 8'h24;

	// field positions
	localparam int MSK_FMT_BIT = 31;
	localparam int MBID_IDE_BIT = 31;
	localparam int GIM_RFP_BIT = 0;
	localparam int GIM_RML_BIT = 1;

	// writable bits; mask bits 30:29 and id bits 30:29 stay zero
	localparam logic [31:0] MASK_WMASK = 32'h9FFFFFFF;
	localparam logic [31:0] MBID_WMASK = 32'h9FFFFFFF;
	localparam logic [31:0] GIM_WMASK = 32'h00000003;

	// identifier bits that take part in a compare
	localparam logic [28:0] EXT_SEL = 29'h1FFFFFFF;
	localparam logic [28:0] STD_SEL = 29'h1FFC0000;

	// reset values
	localparam logic [31:0] RST_ZERO = 32'h00000000;

endpackage : crf_pkg

/* design/crf_rx_filter.sv */
// What this block does
// - 32 remote pending flags; remote frame accepted sets remote and receive pending
// - writing one to receive pending clears it and remote pending together
// - writing zero to receive pending, or anything to remote pending, is ignored
// - data frame into a mailbox with remote pending clears that flag
// - remote pending set with its enable on raises the global interrupt
// - mailboxes 0 to 30 use the shared mask only when enabled
// - frame goes only to the lowest matching mailbox
// - mailbox 31 is compared only when mailboxes 0 to 30 missed
// - mailbox 31 mask applies to mailbox 31 only, when enabled
// - mask bit 31 clear means format must match; set accepts both
// - mask bit zero means bit must match; one means ignored
// - extended frames compare identifier bits 28 to 0
// - standard frames compare identifier bits 28 to 18 only
// - mask bits 30 and 29 read zero; software writes zero
// - after reset all remote pending and mailbox 31 mask bits are zero
// - shared mask behaves for mailboxes 0 to 30 like the mailbox 31 mask
// - frame matching no mailbox changes no flag
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module crf_rx_filter
	import crf_pkg::*;
(
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// register port
	input wire logic [ADDR_W-1:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	// received frame from the protocol engine
	input wire logic RX_VALID,
	input wire logic [ID_W-1:0] RX_ID,
	input wire logic RX_IDE,
	input wire logic RX_REMOTE,
	// store request to the message memory
	output logic STORE_VALID,
	output logic [MB_W-1:0] STORE_MB,
	output logic STORE_OVERWRITE,
	output logic STORE_REMOTE,
	// global interrupt
	output logic GLOBAL_INTERRUPT_OUTPUT
);

	// all state of the block
	typedef struct packed {
		logic [NUM_MB-1:0] receive_pending_flags;
		logic [NUM_MB-1:0] receive_lost_flags;
		logic [NUM_MB-1:0] remote_frame_pending_flags;
		logic [31:0] global_interrupt_mask;
		logic [31:0] shared_id_mask;
		logic [31:0] mailbox31_id_mask;
		logic [NUM_MB-1:0] mb_receive;
		logic [NUM_MB-1:0] mb_mask_enable;
		logic [MB_W-1:0] mb_index;
		logic [NUM_MB-1:0][31:0] mb_id;
		logic [31:0] rdata;
		logic store_valid;
		logic [MB_W-1:0] store_mb;
		logic store_overwrite;
		logic store_remote;
		logic irq;
	} crf_state_t;

	crf_state_t q;
	crf_state_t d;

	// filter results
	logic [NUM_MB-1:0] id_hit;
	logic [NUM_MB-2:0] low_req;
	logic low_found;
	logic [MB_W-1:0] low_idx;
	logic top_take;
	logic accept;
	logic [MB_W-1:0] acc_idx;
	logic [NUM_MB-1:0] acc_vec;
	logic [NUM_MB-1:0] acc_remote;
	logic [NUM_MB-1:0] acc_data;
	logic [NUM_MB-1:0] cpu_clr;

	// address decode, shared by the write and read paths
	function automatic logic hit_at(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] ofs
	);
		hit_at = (a == ofs);
	endfunction : hit_at

	// read multiplexer; unmapped offsets read zero
	function automatic logic [31:0] read_mux(
		input logic [ADDR_W-1:0] a,
		input crf_state_t s
	);
		read_mux = RST_ZERO;
		if (hit_at(a, OFS_RMP)) begin
			read_mux = s.receive_pending_flags;
		end
		if (hit_at(a, OFS_RML)) begin
			read_mux = s.receive_lost_flags;
		end
		if (hit_at(a, OFS_RFP)) begin
			read_mux = s.remote_frame_pending_flags;
		end
		if (hit_at(a, OFS_GIM)) begin
			read_mux = s.global_interrupt_mask;
		end
		if (hit_at(a, OFS_GAM)) begin
			read_mux = s.shared_id_mask;
		end
		if (hit_at(a, OFS_LAM)) begin
			read_mux = s.mailbox31_id_mask;
		end
		if (hit_at(a, OFS_MBDIR)) begin
			read_mux = s.mb_receive;
		end
		if (hit_at(a, OFS_MBAME)) begin
			read_mux = s.mb_mask_enable;
		end
		if (hit_at(a, OFS_MBIDX)) begin
			read_mux = {{(32 - MB_W){1'b0}}, s.mb_index};
		end
		if (hit_at(a, OFS_MBID)) begin
			read_mux = s.mb_id[s.mb_index];
		end
	endfunction : read_mux

	// mailboxes 0 to 30 compare under the shared mask
	genvar gi;
	generate
		for (gi = 0; gi < NUM_MB - 1; gi++) begin : g_low
			crf_id_match u_match (
				.rx_id(RX_ID),
				.rx_ide(RX_IDE),
				.mb_id(q.mb_id[gi]),
				.mask(q.shared_id_mask),
				.mask_en(q.mb_mask_enable[gi]),
				.hit(id_hit[gi])
			);
			// only receive mailboxes take a frame in this block
			assign low_req[gi] = id_hit[gi] & q.mb_receive[gi];
		end
	endgenerate

	// mailbox 31 is receive-only and alone sees the local mask
	crf_id_match u_match_top (
		.rx_id(RX_ID),
		.rx_ide(RX_IDE),
		.mb_id(q.mb_id[NUM_MB-1]),
		.mask(q.mailbox31_id_mask),
		.mask_en(q.mb_mask_enable[NUM_MB-1]),
		.hit(id_hit[NUM_MB-1])
	);

	// lowest matching mailbox wins; later ones never see the frame
	crf_first_pick #(
		.N(NUM_MB - 1),
		.IW(MB_W)
	) u_pick (
		.req(low_req),
		.found(low_found),
		.idx(low_idx)
	);

	// fallback only on a miss in 0 to 30
	assign top_take = ~low_found & id_hit[NUM_MB-1];
	// no match: accept stays low and no flag moves
	assign accept = RX_VALID & (low_found | top_take);
	assign acc_idx = low_found ? low_idx : MB_W'(NUM_MB - 1);
	assign acc_vec = accept ? (NUM_MB'(1) << acc_idx) : '0;
	assign acc_remote = RX_REMOTE ? acc_vec : '0;
	assign acc_data = RX_REMOTE ? '0 : acc_vec;

	// write of one to receive pending clears; zeros do nothing
	assign cpu_clr = (REG_WR && hit_at(REG_ADDR, OFS_RMP)) ? REG_WDATA : '0;

	// next state
	always_comb begin
		d = q;
		d.store_valid = 1'b0;
		d.rdata = RST_ZERO;

		// configuration writes; masks keep bits 30:29 at zero
		if (REG_WR) begin
			if (hit_at(REG_ADDR, OFS_GIM)) begin
				d.global_interrupt_mask = REG_WDATA & GIM_WMASK;
			end
			if (hit_at(REG_ADDR, OFS_GAM)) begin
				d.shared_id_mask = REG_WDATA & MASK_WMASK;
			end
			// takes effect on the next frame, even mid-operation
			if (hit_at(REG_ADDR, OFS_LAM)) begin
				d.mailbox31_id_mask = REG_WDATA & MASK_WMASK;
			end
			if (hit_at(REG_ADDR, OFS_MBDIR)) begin
				d.mb_receive = REG_WDATA;
			end
			if (hit_at(REG_ADDR, OFS_MBAME)) begin
				d.mb_mask_enable = REG_WDATA;
			end
			if (hit_at(REG_ADDR, OFS_MBIDX)) begin
				d.mb_index = REG_WDATA[MB_W-1:0];
			end
			if (hit_at(REG_ADDR, OFS_MBID)) begin
				d.mb_id[q.mb_index] = REG_WDATA & MBID_WMASK;
			end
			// writes to the lost and remote flag offsets fall through
		end

		// receive pending: set beats a clear in the same cycle
		d.receive_pending_flags = (q.receive_pending_flags & ~cpu_clr) | acc_vec;
		// lost: a frame landing on a still pending mailbox
		d.receive_lost_flags = (q.receive_lost_flags & ~cpu_clr)
			| (acc_vec & q.receive_pending_flags);
		// remote pending: hardware set only, cleared by data overwrite
		d.remote_frame_pending_flags = (q.remote_frame_pending_flags & ~cpu_clr & ~acc_data)
			| acc_remote;

		// tell the message memory where to put the frame
		if (accept) begin
			d.store_valid = 1'b1;
			d.store_mb = acc_idx;
			d.store_overwrite = q.receive_pending_flags[acc_idx];
			d.store_remote = RX_REMOTE;
		end

		// interrupt follows the flags in the same cycle they change
		d.irq = (|d.remote_frame_pending_flags & d.global_interrupt_mask[GIM_RFP_BIT])
			| (|d.receive_lost_flags & d.global_interrupt_mask[GIM_RML_BIT]);

		// read data stands only in the cycle after the strobe
		if (REG_RD) begin
			d.rdata = read_mux(REG_ADDR, q);
		end
	end

	// state register; everything clears, masks and remote flags included
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state register
	assign REG_RDATA = q.rdata;
	assign STORE_VALID = q.store_valid;
	assign STORE_MB = q.store_mb;
	assign STORE_OVERWRITE = q.store_overwrite;
	assign STORE_REMOTE = q.store_remote;
	assign GLOBAL_INTERRUPT_OUTPUT = q.irq;

endmodule : crf_rx_filter

/* verification/crf_checker.sv */
`timescale 1ns/1ns
module crf_checker
	import crf_pkg::*;
(
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// register port
	input wire logic [ADDR_W-1:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [31:0] REG_RDATA,
	// frame in, store out
	input wire logic RX_VALID,
	input wire logic RX_REMOTE,
	input wire logic STORE_VALID,
	input wire logic [MB_W-1:0] STORE_MB,
	input wire logic STORE_REMOTE,
	input wire logic GLOBAL_INTERRUPT_OUTPUT
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);
	logic [1:0] gim_q;
	// enable copy; irq check only holds with the lost enable off
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST)
			gim_q <= 2'h0;
		else if (REG_WR && REG_ADDR == OFS_GIM)
			gim_q <= REG_WDATA[1:0];
	end
	sequence rfp_rd;
		REG_RD && REG_ADDR == OFS_RFP;
	endsequence
	sequence rfp_wr_quiet;
		REG_WR && REG_ADDR == OFS_RFP && !RX_VALID;
	endsequence
	a_store_has_rx: assert property (STORE_VALID |-> $past(RX_VALID))
		else $error("store without a frame");
	a_remote_kind: assert property (STORE_VALID |-> STORE_REMOTE == $past(RX_REMOTE))
		else $error("store kind differs from frame");
	a_reset_quiet: assert property ($fell(RST) |-> !STORE_VALID && !GLOBAL_INTERRUPT_OUTPUT)
		else $error("output active after reset");
	a_rfp_set_seen: assert property (STORE_VALID && STORE_REMOTE ##0 rfp_rd
		|=> REG_RDATA[$past(STORE_MB)]) else $error("remote flag not set");
	a_rfp_data_clr: assert property (STORE_VALID && !STORE_REMOTE ##0 rfp_rd
		|=> !REG_RDATA[$past(STORE_MB)]) else $error("remote flag kept over data");
	a_mask_rsvd_zero: assert property (REG_RD && (REG_ADDR == OFS_LAM || REG_ADDR == OFS_GAM)
		|=> REG_RDATA[30:29] == 2'h0) else $error("reserved mask bits set");
	a_irq_matches: assert property (rfp_rd ##0 gim_q == 2'h1
		|=> (|REG_RDATA) == $past(GLOBAL_INTERRUPT_OUTPUT)) else $error("irq differs");
	a_rfp_wr_ignored: assert property (REG_RD && REG_ADDR == OFS_RFP && !RX_VALID
		##1 rfp_wr_quiet ##1 rfp_rd |=> REG_RDATA == $past(REG_RDATA, 2))
		else $error("remote flags changed by write");
	a_rmp_w1c: assert property (REG_WR && REG_ADDR == OFS_RMP && !RX_VALID ##1 rfp_rd
		|=> (REG_RDATA & $past(REG_WDATA, 2)) == 32'h0) else $error("remote flag not cleared");
endmodule : crf_checker

bind crf_rx_filter crf_checker u_chk (.*);

/* verification/crf_frame_src.sv */
`timescale 1ns/1ns
module crf_frame_src
	import crf_pkg::*;
(
	// clock
	input wire logic REF_CLK,
	// frame to the filter
	output logic RX_VALID,
	output logic [ID_W-1:0] RX_ID,
	output logic RX_IDE,
	output logic RX_REMOTE
);
	// idle lines
	initial begin
		RX_VALID = 1'b0;
		RX_ID = '0;
		RX_IDE = 1'b0;
		RX_REMOTE = 1'b0;
	end
	// one-cycle frame; afterwards the inverse so stale fields never look valid
	task automatic send(input logic [ID_W-1:0] id, input logic ide, input logic rem);
		RX_VALID <= 1'b1;
		RX_ID <= id;
		RX_IDE <= ide;
		RX_REMOTE <= rem;
		@(posedge REF_CLK);
		RX_VALID <= 1'b0;
		RX_ID <= ~id;
		RX_IDE <= ~ide;
		RX_REMOTE <= ~rem;
	endtask : send
endmodule : crf_frame_src

/* verification/tb_top.sv */
`timescale 1ns/1ns
module tb_top
	import crf_pkg::*;
;
	logic REF_CLK = 1'b0;
	logic RST = 1'b1;
	logic [ADDR_W-1:0] REG_ADDR = '0;
	logic [31:0] REG_WDATA = '0;
	logic REG_WR = 1'b0;
	logic REG_RD = 1'b0;
	logic [31:0] REG_RDATA;
	logic RX_VALID;
	logic [ID_W-1:0] RX_ID;
	logic RX_IDE;
	logic RX_REMOTE;
	logic STORE_VALID;
	logic [MB_W-1:0] STORE_MB;
	logic STORE_OVERWRITE;
	logic STORE_REMOTE;
	logic GLOBAL_INTERRUPT_OUTPUT;
	int fail_count = 0;
	int n_tests = 0;
	int seed = 77;
	int cycles = 0;
	logic [31:0] rfp_exp = '0;
	// receive pending model, drives the expected overwrite flag
	logic [31:0] rmp_exp = '0;
	logic [31:0] v;
	logic [31:0] r;
	crf_rx_filter dut (.*);
	crf_frame_src pm (.*);
	always #20 REF_CLK = ~REF_CLK;
	// hang guard, far above the ~2000 cycles the run needs
	always @(posedge REF_CLK) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			final_report();
		end
	end
	task automatic final_report();
		$display("summary: %0d checks, %0d mismatches", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// one bus cycle; v picks up the data of a read issued one cycle earlier
	task automatic bus(input logic rs, input logic ws, input logic [7:0] a, input logic [31:0] d);
		REG_RD <= rs;
		REG_WR <= ws;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge REF_CLK);
		v = REG_RDATA;
	endtask : bus
	task automatic rd(input logic [7:0] a);
		bus(1'b1, 1'b0, a, '0);
		bus(1'b0, 1'b0, a, '0);
	endtask : rd
	// expected {hit, mailbox} for the filter set up below
	function automatic logic [5:0] exp_mb(input logic [28:0] id, input logic ide);
		if (ide && id == 29'h123)
			return 6'h23;
		if (ide && id[28:8] == 21'h1 && id[3:0] == 4'h3)
			return 6'h25;
		if (!ide || id[7:0] == 8'h55)
			return 6'h3F;
		return 6'h00;
	endfunction : exp_mb
	// frame, then a remote flag read in the store cycle
	task automatic frame(input logic [28:0] id, input logic ide, input logic rem);
		logic [5:0] e;
		logic ov;
		e = exp_mb(id, ide);
		ov = e[5] & rmp_exp[e[4:0]];
		pm.send(id, ide, rem);
		bus(1'b1, 1'b0, OFS_RFP, '0);
		check({25'h0, STORE_REMOTE & e[5], STORE_VALID, e[5] ? STORE_MB : 5'h0},
			{25'h0, rem & e[5], e});
		check({31'h0, e[5] & STORE_OVERWRITE}, {31'h0, ov});
		if (e[5]) begin
			rfp_exp[e[4:0]] = rem;
			rmp_exp[e[4:0]] = 1'b1;
		end
		bus(1'b0, 1'b0, OFS_RFP, '0);
		check(v, rfp_exp);
		check({31'h0, GLOBAL_INTERRUPT_OUTPUT}, {31'h0, |rfp_exp});
	endtask : frame
	initial begin
		repeat (8) @(posedge REF_CLK);
		RST <= 1'b0;
		rd(OFS_RFP);
		check(v, RST_ZERO);
		rd(OFS_LAM);
		check(v, RST_ZERO);
		bus(1'b0, 1'b1, OFS_LAM, 32'hFFFFFFFF);
		rd(OFS_LAM);
		check(v, 32'h9FFFFFFF);
		rd(8'hFC);
		check(v, 32'h0);
		$display("test reset and registers done");
		// filters set once, before any traffic
		bus(1'b0, 1'b1, OFS_GAM, 32'h000000F0);
		bus(1'b0, 1'b1, OFS_LAM, 32'h9FFFFF00);
		bus(1'b0, 1'b1, OFS_MBDIR, 32'h00000028);
		bus(1'b0, 1'b1, OFS_MBAME, 32'h80000020);
		bus(1'b0, 1'b1, OFS_GIM, 32'h00000001);
		bus(1'b0, 1'b1, OFS_MBIDX, 32'h00000003);
		bus(1'b0, 1'b1, OFS_MBID, 32'h80000123);
		bus(1'b0, 1'b1, OFS_MBIDX, 32'h00000005);
		bus(1'b0, 1'b1, OFS_MBID, 32'h80000123);
		bus(1'b0, 1'b1, OFS_MBIDX, 32'h0000001F);
		bus(1'b0, 1'b1, OFS_MBID, 32'h80000055);
		rd(OFS_GIM);
		check(v, 32'h00000001);
		// corners: tie, shared mask, fallback, standard, miss, data over remote
		frame(29'h123, 1'b1, 1'b1);
		frame(29'h1A3, 1'b1, 1'b1);
		frame(29'h10000155, 1'b1, 1'b1);
		frame(29'h10000123, 1'b1, 1'b1);
		frame(29'h1FFFFFFF, 1'b0, 1'b1);
		frame(29'h156, 1'b1, 1'b0);
		frame(29'h123, 1'b1, 1'b0);
		$display("test corner frames done");
		for (int i = 0; i < 300; i++) begin
			r = $random(seed);
			frame({21'h1, r[7:4], r[8] ? 4'h3 : 4'h5}, r[9], r[10]);
			if (r[11]) begin
				bus(1'b1, 1'b0, OFS_RFP, '0);
				bus(1'b0, 1'b1, OFS_RFP, $random(seed));
				rd(OFS_RFP);
				check(v, rfp_exp);
				bus(1'b0, 1'b1, OFS_RMP, r);
				rfp_exp &= ~r;
				rmp_exp &= ~r;
				rd(OFS_RFP);
				check(v, rfp_exp);
			end
		end
		$display("test random frames done");
		final_report();
	end
endmodule : tb_top
